/* File: src/acfg_bank.sv */
// Purpose: configuration register bank of the converter, steering power,
//          clocking, test pattern, output format, reference and sync
// Assumes: register port strobes come from the serial port engine, SYS_CLK
// Notes:   shadowed registers act only after a transfer command
// Functional notes
// - internal power field: 00 and 11 run, 01 full power-down, 10 standby
// - one bit picks pin action: clear gives power-down, set gives standby
// - divide ratio is field plus one; nonzero field forces stabilizer on
// - test field picks midscale, full scales, checkerboard, two sequences; replaces data
// - format 00 and 11 offset binary, 01 twos complement, 10 gray; invert bit
// - phase field delays divider input 0 to 7 cycles; bit inverts output clock
// - shadowed registers act only after 0x01 to transfer; all update, bit self-clears
// - no sync function works unless master sync enable is set
// - master and divider sync enable set: every sync pulse realigns divider
// - next-only set: align to first pulse, then divider sync enable self-clears
module acfg_bank
    import acfg_pkg::*;
(
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST,
    input  wire logic                    SOFT_RST,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    input  wire logic [acfg_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic [acfg_pkg::DATA_W-1:0] REG_WDATA,
    output logic      [acfg_pkg::DATA_W-1:0] REG_RDATA,
    output logic                         REG_RVALID,
    input  wire logic                    PDWN_PIN,
    input  wire logic                    SYNC_PULSE,
    input  wire logic [15:0]             CHECK_SIGNATURE,
    output acfg_pkg::acfg_power_t        POWER_STATE,
    output logic                         STABILIZER_ON,
    output logic      [2:0]              DIVIDE_FIELD,
    output logic      [2:0]              DIVIDE_PHASE,
    output logic                         DIVIDER_ALIGN,
    output logic      [2:0]              PATTERN_SELECT,
    output logic                         PATTERN_ACTIVE,
    output logic                         LONG_PSEUDO_RANDOM_PATTERN_RESET,
    output logic                         SHORT_PSEUDO_RANDOM_PATTERN_RESET,
    output logic                         BUILT_IN_SELF_CHECK_EN,
    output logic                         BUILT_IN_SELF_CHECK_RESET,
    output acfg_pkg::acfg_format_t       DATA_FORMAT,
    output logic                         DATA_INVERT,
    output logic                         OUTPUT_DISABLE,
    output logic                         OUTPUT_LVDS,
    output logic                         OUTPUT_REDUCED_DRIVE,
    output logic                         DATA_OUTPUT_CLOCK_INVERT,
    output logic      [4:0]              DATA_OUTPUT_CLOCK_DELAY,
    output logic      [1:0]              REFERENCE_SPAN,
    output logic                         DITHER_EN
);
    import acfg_pkg::*;

    logic             reg_rst;
    logic             xfer;
    logic [SH_COUNT-1:0] sh_wr;
    logic [7:0]       sh_master [SH_COUNT];
    logic [7:0]       sh_active [SH_COUNT];
    logic [7:0]       dither_control;
    logic [7:0]       divider_sync_control;
    logic [7:0]       next_dither_control;
    logic [7:0]       next_divider_sync_control;
    logic             sync_gate;
    logic             next_align;
    logic [7:0]       next_rdata;
    logic             next_rvalid;
    acfg_power_t      next_power;
    acfg_format_t     next_format;

    // device reset and soft reset both restore defaults
    assign reg_rst = RST | SOFT_RST;

    // transfer command: write 0x01 to the transfer address, acts once, nothing is stored
    assign xfer = REG_WR && (REG_ADDR == OFS_XFER) && (REG_WDATA == XFER_CMD);

    // write decode for the shadowed group
    always_comb begin
        for (int i = 0; i < SH_COUNT; i++) begin
            sh_wr[i] = REG_WR && (REG_ADDR == SH_ADDR[i]);
        end
    end

    // shadowed bytes: master takes writes, active follows on transfer
    for (genvar gi = 0; gi < SH_COUNT; gi++) begin : g_shadow
        acfg_shadow_reg #(
            .RESET (SH_RESET[gi]),
            .MASK  (SH_MASK[gi])
        ) u_reg (
            .clk     (SYS_CLK),
            .rst     (reg_rst),
            .wr_en   (sh_wr[gi]),
            .wr_data (REG_WDATA),
            .xfer    (xfer),
            .master  (sh_master[gi]),
            .active  (sh_active[gi])
        );
    end

    // sync pulse passes only with master and divider sync enables set
    assign sync_gate = SYNC_PULSE && divider_sync_control[SYNC_MASTER]
                       && divider_sync_control[SYNC_DIV_EN];

    // unshadowed registers: dither and sync control act at once
    always_comb begin
        next_dither_control       = dither_control;
        next_divider_sync_control = divider_sync_control;
        if (REG_WR && REG_ADDR == OFS_DITHER) begin
            next_dither_control = REG_WDATA & DITHER_MASK;
        end
        if (sync_gate && divider_sync_control[SYNC_ONCE]) begin
            next_divider_sync_control[SYNC_DIV_EN] = 1'b0;
        end
        // a host write in the same cycle wins over the self-clear
        if (REG_WR && REG_ADDR == OFS_SYNC) begin
            next_divider_sync_control = REG_WDATA & SYNC_MASK;
        end
        next_align = sync_gate;
    end

    always_ff @(posedge SYS_CLK) begin
        if (reg_rst) begin
            dither_control       <= DITHER_RESET;
            divider_sync_control <= SYNC_RESET;
        end else begin
            dither_control       <= next_dither_control;
            divider_sync_control <= next_divider_sync_control;
        end
    end

    // read mux: master copies read back, unmapped and transfer read zero
    always_comb begin
        next_rdata  = 8'h00;
        next_rvalid = REG_RD;
        if (REG_RD) begin
            for (int i = 0; i < SH_COUNT; i++) begin
                if (REG_ADDR == SH_ADDR[i]) begin
                    next_rdata = sh_master[i];
                end
            end
            unique case (REG_ADDR)
                OFS_SIG_LOW:  next_rdata = CHECK_SIGNATURE[7:0];
                OFS_SIG_HIGH: next_rdata = CHECK_SIGNATURE[15:8];
                OFS_DITHER:   next_rdata = dither_control;
                OFS_SYNC:     next_rdata = divider_sync_control;
                default:      next_rdata = next_rdata;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (reg_rst) begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RDATA  <= next_rdata;
            REG_RVALID <= next_rvalid;
        end
    end

    // power state: the pin overrides the internal field while asserted
    always_comb begin
        if (PDWN_PIN) begin
            next_power = sh_active[SH_POWER][PWR_PIN_BIT] ? ACFG_STANDBY : ACFG_OFF;
        end else begin
            unique case (sh_active[SH_POWER][PWR_INT_LSB +: 2])
                PWR_CODE_OFF:     next_power = ACFG_OFF;
                PWR_CODE_STANDBY: next_power = ACFG_STANDBY;
                default:          next_power = ACFG_RUN;
            endcase
        end
    end

    // output format: 11 falls back to offset binary
    always_comb begin
        unique case (sh_active[SH_FORMAT][FMT_LSB +: 2])
            FMT_CODE_TWOS: next_format = ACFG_TWOS_COMP;
            FMT_CODE_GRAY: next_format = ACFG_GRAY;
            default:       next_format = ACFG_OFFSET_BIN;
        endcase
    end

    // control outputs, registered from the active copies, the power-down pin, the dither register and the sync gate
    always_ff @(posedge SYS_CLK) begin
        if (reg_rst) begin
            POWER_STATE                       <= ACFG_RUN;
            STABILIZER_ON                     <= SH_RESET[SH_STAB][STAB_BIT];
            DIVIDE_FIELD                      <= 3'h0;
            DIVIDE_PHASE                      <= 3'h0;
            DIVIDER_ALIGN                     <= 1'b0;
            PATTERN_SELECT                    <= 3'h0;
            PATTERN_ACTIVE                    <= 1'b0;
            LONG_PSEUDO_RANDOM_PATTERN_RESET  <= 1'b0;
            SHORT_PSEUDO_RANDOM_PATTERN_RESET <= 1'b0;
            BUILT_IN_SELF_CHECK_EN            <= 1'b0;
            BUILT_IN_SELF_CHECK_RESET         <= SH_RESET[SH_CHECK][CHK_RST_BIT];
            DATA_FORMAT                       <= ACFG_OFFSET_BIN;
            DATA_INVERT                       <= 1'b0;
            OUTPUT_DISABLE                    <= 1'b0;
            OUTPUT_LVDS                       <= 1'b0;
            OUTPUT_REDUCED_DRIVE              <= 1'b0;
            DATA_OUTPUT_CLOCK_INVERT          <= 1'b0;
            DATA_OUTPUT_CLOCK_DELAY           <= 5'h00;
            REFERENCE_SPAN                    <= SH_RESET[SH_SPAN][SPAN_LSB +: 2];
            DITHER_EN                         <= 1'b0;
        end else begin
            POWER_STATE                       <= next_power;
            STABILIZER_ON                     <= sh_active[SH_STAB][STAB_BIT]
                                                 | (|sh_active[SH_DIVIDE][DIV_LSB +: 3]);
            DIVIDE_FIELD                      <= sh_active[SH_DIVIDE][DIV_LSB +: 3];
            DIVIDE_PHASE                      <= sh_active[SH_PHASE][PHASE_LSB +: 3];
            DIVIDER_ALIGN                     <= next_align;
            PATTERN_SELECT                    <= sh_active[SH_PATTERN][PAT_LSB +: 3];
            PATTERN_ACTIVE                    <= |sh_active[SH_PATTERN][PAT_LSB +: 3];
            LONG_PSEUDO_RANDOM_PATTERN_RESET  <= sh_active[SH_PATTERN][PAT_LONG_RST];
            SHORT_PSEUDO_RANDOM_PATTERN_RESET <= sh_active[SH_PATTERN][PAT_SHORT_RST];
            BUILT_IN_SELF_CHECK_EN            <= sh_active[SH_CHECK][CHK_EN_BIT];
            BUILT_IN_SELF_CHECK_RESET         <= sh_active[SH_CHECK][CHK_RST_BIT];
            DATA_FORMAT                       <= next_format;
            DATA_INVERT                       <= sh_active[SH_FORMAT][FMT_INV_BIT];
            OUTPUT_DISABLE                    <= sh_active[SH_FORMAT][FMT_OEB_BIT];
            OUTPUT_LVDS                       <= sh_active[SH_FORMAT][FMT_LVDS_BIT];
            OUTPUT_REDUCED_DRIVE              <= sh_active[SH_FORMAT][FMT_DRV_BIT];
            DATA_OUTPUT_CLOCK_INVERT          <= sh_active[SH_PHASE][PHASE_INV_BIT];
            DATA_OUTPUT_CLOCK_DELAY           <= sh_active[SH_DOCDLY][DOCDLY_LSB +: 5];
            REFERENCE_SPAN                    <= sh_active[SH_SPAN][SPAN_LSB +: 2];
            DITHER_EN                         <= dither_control[DITHER_BIT];
        end
    end
endmodule

/* File: src/acfg_pkg.sv */
// Purpose: constants shared by the converter configuration register bank
// Assumes: byte-wide registers, 9-bit register addresses
// Notes:   shadowed registers are listed in one table, indexed by SH_*
package acfg_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [8:0] OFS_POWER    = 9'h0_08;
    localparam logic [8:0] OFS_STAB     = 9'h0_09;
    localparam logic [8:0] OFS_DIVIDE   = 9'h0_0b;
    localparam logic [8:0] OFS_PATTERN  = 9'h0_0d;
    localparam logic [8:0] OFS_CHECK    = 9'h0_0e;
    localparam logic [8:0] OFS_FORMAT   = 9'h0_14;
    localparam logic [8:0] OFS_PHASE    = 9'h0_16;
    localparam logic [8:0] OFS_DOCDLY   = 9'h0_17;
    localparam logic [8:0] OFS_SPAN     = 9'h0_18;
    localparam logic [8:0] OFS_SIG_LOW  = 9'h0_24;
    localparam logic [8:0] OFS_SIG_HIGH = 9'h0_25;
    localparam logic [8:0] OFS_DITHER   = 9'h0_30;
    localparam logic [8:0] OFS_XFER     = 9'h0_ff;
    localparam logic [8:0] OFS_SYNC     = 9'h1_00;

    // shadowed group: index, offset, reset value, writable bits
    localparam int SH_COUNT   = 9;
    localparam int SH_POWER   = 0;
    localparam int SH_STAB    = 1;
    localparam int SH_DIVIDE  = 2;
    localparam int SH_PATTERN = 3;
    localparam int SH_CHECK   = 4;
    localparam int SH_FORMAT  = 5;
    localparam int SH_PHASE   = 6;
    localparam int SH_DOCDLY  = 7;
    localparam int SH_SPAN    = 8;
    localparam logic [8:0] SH_ADDR [SH_COUNT] = '{OFS_POWER, OFS_STAB, OFS_DIVIDE, OFS_PATTERN,
                                                 OFS_CHECK, OFS_FORMAT, OFS_PHASE, OFS_DOCDLY, OFS_SPAN};
    localparam logic [7:0] SH_RESET [SH_COUNT] = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h04,
                                                  8'h00, 8'h00, 8'h00, 8'hc0};
    localparam logic [7:0] SH_MASK [SH_COUNT] = '{8'ha3, 8'h01, 8'h07, 8'h37, 8'h05,
                                                 8'hd7, 8'h87, 8'h1f, 8'hc0};

    // unshadowed registers
    localparam logic [7:0] DITHER_RESET = 8'h00;
    localparam logic [7:0] DITHER_MASK  = 8'h10;
    localparam logic [7:0] SYNC_RESET   = 8'h00;
    localparam logic [7:0] SYNC_MASK    = 8'h07;
    localparam logic [7:0] XFER_CMD     = 8'h01;

    // field positions
    localparam int PWR_INT_LSB   = 0;
    localparam int PWR_PIN_BIT   = 5;
    localparam int STAB_BIT      = 0;
    localparam int DIV_LSB       = 0;
    localparam int PAT_LSB       = 0;
    localparam int PAT_SHORT_RST = 4;
    localparam int PAT_LONG_RST  = 5;
    localparam int CHK_EN_BIT    = 0;
    localparam int CHK_RST_BIT   = 2;
    localparam int FMT_LSB       = 0;
    localparam int FMT_INV_BIT   = 2;
    localparam int FMT_OEB_BIT   = 4;
    localparam int FMT_LVDS_BIT  = 6;
    localparam int FMT_DRV_BIT   = 7;
    localparam int PHASE_LSB     = 0;
    localparam int PHASE_INV_BIT = 7;
    localparam int DOCDLY_LSB    = 0;
    localparam int SPAN_LSB      = 6;
    localparam int DITHER_BIT    = 4;
    localparam int SYNC_MASTER   = 0;
    localparam int SYNC_DIV_EN   = 1;
    localparam int SYNC_ONCE     = 2;

    // internal power-down and output format field codes
    localparam logic [1:0] PWR_CODE_OFF     = 2'h1;
    localparam logic [1:0] PWR_CODE_STANDBY = 2'h2;
    localparam logic [1:0] FMT_CODE_TWOS    = 2'h1;
    localparam logic [1:0] FMT_CODE_GRAY    = 2'h2;

    typedef enum logic [1:0] {ACFG_RUN, ACFG_OFF, ACFG_STANDBY} acfg_power_t;
    typedef enum logic [1:0] {ACFG_OFFSET_BIN, ACFG_TWOS_COMP, ACFG_GRAY} acfg_format_t;
endpackage

/* File: src/acfg_shadow_reg.sv */
// Purpose: one shadowed configuration byte, master copy plus active copy
// Assumes: write and transfer strobes are one-cycle pulses
// Notes:   bits outside MASK are held at zero
module acfg_shadow_reg #(
    parameter logic [7:0] RESET = 8'h00,
    parameter logic [7:0] MASK  = 8'hff
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       xfer,
    output logic      [7:0] master,
    output logic      [7:0] active
);
    logic [7:0] next_master;
    logic [7:0] next_active;

    // host writes land in the master copy; transfer copies it to active
    always_comb begin
        next_master = wr_en ? (wr_data & MASK) : master;
        next_active = xfer ? master : active;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            master <= RESET;
            active <= RESET;
        end else begin
            master <= next_master;
            active <= next_active;
        end
    end
endmodule

/* File: test/acfg_bank_props.sv */
// Purpose: port checks for the configuration register bank
// Assumes: one clock domain, resets synchronous and active high
// Notes:   attached by bind to every bank instance
module acfg_bank_props (
    input wire logic                          SYS_CLK,
    input wire logic                          RST,
    input wire logic                          SOFT_RST,
    input wire logic                          REG_WR,
    input wire logic                          REG_RD,
    input wire logic [acfg_pkg::ADDR_W-1:0]   REG_ADDR,
    input wire logic [acfg_pkg::DATA_W-1:0]   REG_WDATA,
    input wire logic [acfg_pkg::DATA_W-1:0]   REG_RDATA,
    input wire logic                          REG_RVALID,
    input wire logic                          PDWN_PIN,
    input wire logic                          SYNC_PULSE,
    input wire acfg_pkg::acfg_power_t         POWER_STATE,
    input wire logic                          STABILIZER_ON,
    input wire logic [2:0]                    DIVIDE_FIELD,
    input wire logic                          DIVIDER_ALIGN,
    input wire logic [2:0]                    PATTERN_SELECT,
    input wire logic                          PATTERN_ACTIVE,
    input wire logic                          DITHER_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    import acfg_pkg::*;
    logic xfer_cmd;
    // a valid transfer command seen on the register port
    assign xfer_cmd = REG_WR && REG_ADDR == OFS_XFER && REG_WDATA == XFER_CMD;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST || SOFT_RST);
    sequence s_dither_wr; REG_WR && REG_ADDR == OFS_DITHER; endsequence
    property p_read_answer; REG_RD |=> REG_RVALID; endproperty
    property p_read_idle; !REG_RVALID |-> REG_RDATA == 8'h00; endproperty
    property p_dither; s_dither_wr |-> ##2 DITHER_EN == $past(REG_WDATA[DITHER_BIT], 2); endproperty
    // a reset also restores the outputs, so a change right after one is legal
    property p_shadow;
        $changed(DIVIDE_FIELD) || $changed(PATTERN_SELECT) |-> $past(xfer_cmd, 2) || $past(RST || SOFT_RST);
    endproperty
    property p_pin; PDWN_PIN |=> POWER_STATE != ACFG_RUN; endproperty
    property p_stab; DIVIDE_FIELD != 3'h0 |-> STABILIZER_ON; endproperty
    property p_pattern; PATTERN_ACTIVE == (PATTERN_SELECT != 3'h0); endproperty
    property p_align; DIVIDER_ALIGN |-> $past(SYNC_PULSE); endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    a_read_idle: assert property (p_read_idle) else $error("read data not idle");
    a_dither: assert property (p_dither) else $error("dither enable wrong");
    a_shadow: assert property (p_shadow) else $error("shadow changed without transfer");
    a_pin: assert property (p_pin) else $error("pin did not power down");
    a_stab: assert property (p_stab) else $error("stabilizer not forced");
    a_pattern: assert property (p_pattern) else $error("pattern active wrong");
    a_align: assert property (p_align) else $error("align without sync pulse");
endmodule
bind acfg_bank acfg_bank_props chk_u (.SYS_CLK, .RST, .SOFT_RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .REG_RVALID, .PDWN_PIN, .SYNC_PULSE, .POWER_STATE, .STABILIZER_ON, .DIVIDE_FIELD,
    .DIVIDER_ALIGN, .PATTERN_SELECT, .PATTERN_ACTIVE, .DITHER_EN);

/* File: test/acfg_host.sv */
// Purpose: host side of the register port, issuing writes and reads
// Assumes: strobes are one-cycle pulses taken at the rising edge
// Notes:   released address and data show the inverse of the last value
module acfg_host (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [8:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    import acfg_pkg::*;
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
    end
    // one write, held until the taking edge
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // one read, answer sampled once the taking edge has settled
    task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
    // transfer command moves all shadowed masters into use
    task automatic xfer();
        wr(OFS_XFER, XFER_CMD);
    endtask
endmodule

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the configuration register bank
// Assumes: host model drives the register port, bench drives the rest
// Notes:   expected values come from the register table constants
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acfg_pkg::*;
    logic clk, rst, soft_rst, reg_wr, reg_rd, reg_rvalid, pdwn_pin, sync_pulse, stabilizer_on;
    logic divider_align, pattern_active, data_invert, clock_invert, dither_en, v, al;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [2:0] divide_field, divide_phase, pattern_select;
    logic [15:0] signature;
    wire  [6:0] misc; // pattern resets, self check, output enable, type and drive
    wire  [4:0] dly;
    wire  [1:0] span;
    acfg_power_t power_state;
    acfg_format_t data_format;
    int n_mismatch = 0;
    int cmp_count = 0;
    acfg_power_t pw [4] = '{ACFG_RUN, ACFG_OFF, ACFG_STANDBY, ACFG_RUN};
    acfg_format_t fm [4] = '{ACFG_OFFSET_BIN, ACFG_TWOS_COMP, ACFG_GRAY, ACFG_OFFSET_BIN};
    acfg_host host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    acfg_bank dut_u (.SYS_CLK(clk), .RST(rst), .SOFT_RST(soft_rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .PDWN_PIN(pdwn_pin), .SYNC_PULSE(sync_pulse), .CHECK_SIGNATURE(signature), .POWER_STATE(power_state),
        .STABILIZER_ON(stabilizer_on), .DIVIDE_FIELD(divide_field), .DIVIDE_PHASE(divide_phase),
        .DIVIDER_ALIGN(divider_align), .PATTERN_SELECT(pattern_select), .PATTERN_ACTIVE(pattern_active),
        .LONG_PSEUDO_RANDOM_PATTERN_RESET(misc[0]), .SHORT_PSEUDO_RANDOM_PATTERN_RESET(misc[1]),
        .BUILT_IN_SELF_CHECK_EN(misc[2]), .BUILT_IN_SELF_CHECK_RESET(misc[3]), .DATA_FORMAT(data_format),
        .DATA_INVERT(data_invert), .OUTPUT_DISABLE(misc[4]), .OUTPUT_LVDS(misc[5]),
        .OUTPUT_REDUCED_DRIVE(misc[6]), .DATA_OUTPUT_CLOCK_INVERT(clock_invert),
        .DATA_OUTPUT_CLOCK_DELAY(dly), .REFERENCE_SPAN(span), .DITHER_EN(dither_en));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // compare one value and count it
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read a register and compare data and answer strobe
    task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
        host_u.rd(a, d, v);
        chk("read valid", 8'h01, {7'h00, v});
        chk("read data", e, d);
    endtask
    // let n edges pass, then step past the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one sync pulse, align output sampled after the taking edge
    task automatic pulse();
        @(posedge clk);
        sync_pulse <= 1'b1;
        @(posedge clk);
        sync_pulse <= 1'b0;
        #1;
        al = divider_align;
    endtask
    // print counts and verdict, then end the run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    // main test sequence
    initial begin
        rst = 1'b1;
        soft_rst = 1'b0;
        pdwn_pin = 1'b0;
        sync_pulse = 1'b0;
        signature = 16'ha53c;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < SH_COUNT; i++)
            rdchk(SH_ADDR[i], SH_RESET[i]);
        rdchk(OFS_SYNC, SYNC_RESET);
        chk("stabilizer", 8'h01, {7'h00, stabilizer_on});
        chk("misc", 8'h08, {1'b0, misc});
        chk("clock delay", 8'h00, {3'h0, dly});
        chk("span", {6'h00, SH_RESET[SH_SPAN][SPAN_LSB +: 2]}, {6'h00, span});
        for (int i = 0; i < SH_COUNT; i++)
            host_u.wr(SH_ADDR[i], 8'hff);
        host_u.wr(OFS_DITHER, 8'hff);
        host_u.wr(OFS_SIG_LOW, 8'hff);
        for (int i = 0; i < SH_COUNT; i++)
            rdchk(SH_ADDR[i], SH_MASK[i]);
        rdchk(OFS_DITHER, DITHER_MASK);
        rdchk(OFS_SIG_LOW, 8'h3c);
        rdchk(OFS_SIG_HIGH, 8'ha5);
        rdchk(9'h013, 8'h00);
        chk("dither", 8'h01, {7'h00, dither_en});
        host_u.wr(OFS_XFER, 8'h03);
        settle(2);
        chk("divide held", 8'h00, {5'h00, divide_field});
        host_u.xfer();
        settle(2);
        chk("divide", 8'h07, {5'h00, divide_field});
        chk("phase", 8'h07, {5'h00, divide_phase});
        chk("clock invert", 8'h01, {7'h00, clock_invert});
        chk("invert", 8'h01, {7'h00, data_invert});
        chk("misc", 8'h7f, {1'b0, misc});
        chk("clock delay", 8'h1f, {3'h0, dly});
        chk("span", 8'h03, {6'h00, span});
        rdchk(OFS_XFER, 8'h00);
        for (int i = 0; i < 8; i++) begin
            host_u.wr(OFS_POWER, 8'(i % 4));
            host_u.wr(OFS_STAB, 8'h00);
            host_u.wr(OFS_DIVIDE, 8'(i));
            host_u.wr(OFS_PATTERN, 8'(i));
            host_u.wr(OFS_FORMAT, 8'(i % 4));
            host_u.wr(OFS_PHASE, 8'(i));
            host_u.xfer();
            settle(2);
            chk("power", 8'(pw[i % 4]), 8'(power_state));
            chk("stabilizer", 8'(i != 0), {7'h00, stabilizer_on});
            chk("divide", 8'(i), {5'h00, divide_field});
            chk("pattern", 8'(i != 0), {7'h00, pattern_active});
            chk("pattern select", 8'(i), {5'h00, pattern_select});
            chk("format", 8'(fm[i % 4]), 8'(data_format));
            chk("phase", 8'(i), {5'h00, divide_phase});
        end
        @(posedge clk);
        pdwn_pin <= 1'b1;
        settle(2);
        chk("pin off", 8'(ACFG_OFF), 8'(power_state));
        host_u.wr(OFS_POWER, 8'h20);
        host_u.xfer();
        settle(2);
        chk("pin standby", 8'(ACFG_STANDBY), 8'(power_state));
        @(posedge clk);
        pdwn_pin <= 1'b0;
        host_u.wr(OFS_SYNC, 8'h06);
        pulse();
        chk("align gated", 8'h00, {7'h00, al});
        host_u.wr(OFS_SYNC, 8'h03);
        pulse();
        chk("align first", 8'h01, {7'h00, al});
        pulse();
        chk("align again", 8'h01, {7'h00, al});
        host_u.wr(OFS_SYNC, 8'h07);
        pulse();
        chk("align once", 8'h01, {7'h00, al});
        rdchk(OFS_SYNC, 8'h05);
        pulse();
        chk("align ignored", 8'h00, {7'h00, al});
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        rdchk(OFS_DIVIDE, 8'h00);
        chk("dither reset", 8'h00, {7'h00, dither_en});
        chk("misc reset", 8'h08, {1'b0, misc});
        give_verdict();
    end
endmodule
